// file: design/wdsr_top.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// RULE1: The invalid-window flag is one whenever either window duration is zero.
// RULE2: The window-changed flag sets when a window duration changes and clears at sequence start.
// RULE3: In answer mode a wrong or mistimed response byte sets the sequence-fault flag; the code sets it for a wrong byte or one after the fourth.
// RULE4: In trigger mode a sequence ending without a trigger sets the time-out flag.
// RULE5: In answer mode a sequence ending with fewer than four bytes sets the time-out flag.
// RULE6: The time-out flag clears on a read, on a good or bad sequence end, and in reset; the code sets it instead at an unserved sequence end.
// RULE7: In the diagnostic state a written one sets the time-out flag, which then signals failure.
// RULE8: Four bytes completed or a trigger seen in the first window set the premature flag.
// RULE9: Responses arrive as written bytes and the response register cannot be read back.
// RULE10: The host may use the time-out flag to realign its servicing, at its own choice.
// RULE11: In answer mode the top status bits report the count of received bytes; the code shows the low two bits, so four reads as zero.
// RULE12: Outside diagnostics flag writes are ignored and only the time-out flag clears on read.
module wdsr_top
	import wdsr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic qa_mode,
	input wire logic diag_state,
	input wire logic [6:0] first_window_duration,
	input wire logic [4:0] second_window_duration,
	input wire wdsr_seq_t seq,
	input wire logic error_trigger_pin,
	input wire wdsr_acc_t acc,
	input wire logic [7:0] expected_answer,
	output logic [7:0] flags_rdata,
	output logic [7:0] response_byte,
	output logic response_valid,
	output logic wd_failure,
	output logic good_event,
	output logic bad_event
);
	wdsr_state_t st_q;
	wdsr_state_t st_d;
	logic trig;
	logic answer;
	logic wrong;
	logic late;
	logic fourth;
	logic missing;
	logic changing;
	logic [7:0] flags;
	logic [2:0] count_base;

	// The pin is only a service trigger in trigger mode.
	assign trig = !qa_mode && error_trigger_pin && seq.trigger;
	assign answer = qa_mode && acc.resp_wr;
	assign wrong = answer && (acc.wdata != expected_answer);
	// A byte that lands with the start strobe belongs to the new sequence and counts from zero.
	assign count_base = seq.seq_start ? 3'h0 : st_q.answers;
	assign late = answer && (count_base >= WDSR_ANSWERS_PER_SEQ);
	assign fourth = answer && (count_base == WDSR_ANSWERS_PER_SEQ - 3'h1);
	assign missing = qa_mode ? (st_q.answers < WDSR_ANSWERS_PER_SEQ) : !st_q.trig_seen; // RULE4 RULE5
	assign changing = (first_window_duration != st_q.win1_prev) ||
		(second_window_duration != st_q.win2_prev);

	always_comb begin
		flags = 8'h00;
		flags[WDSR_EARLY_BIT] = st_q.early;
		flags[WDSR_TIMEOUT_BIT] = st_q.timeout;
		flags[WDSR_SEQ_FAULT_BIT] = st_q.seq_fault;
		flags[WDSR_CHANGED_BIT] = st_q.changed;
		flags[WDSR_INVALID_BIT] = st_q.invalid;
		flags[WDSR_ANS_ERR_BIT] = st_q.ans_err;
		if (qa_mode) begin
			flags[WDSR_COUNT_LSB +: 2] = st_q.answers[1:0]; // RULE11
		end
	end

	always_comb begin
		st_d = st_q;
		st_d.resp_valid = 1'b0;
		st_d.win1_prev = first_window_duration;
		st_d.win2_prev = second_window_duration;
		st_d.invalid = (first_window_duration == WDSR_WIN1_ZERO) ||
			(second_window_duration == WDSR_WIN2_ZERO); // RULE1
		if (acc.flags_rd) begin
			st_d.rd_data = flags;
			st_d.timeout = 1'b0; // RULE6 RULE12
		end
		if (seq.seq_end) begin
			st_d.timeout = 1'b0; // RULE6
		end
		if (seq.seq_start) begin
			st_d.changed = 1'b0; // RULE2
			st_d.seq_fault = 1'b0;
			st_d.ans_err = 1'b0;
			st_d.early = 1'b0;
			st_d.answers = 3'h0;
			st_d.trig_seen = 1'b0;
		end
		if (answer) begin
			// A byte is stored even when wrong so the checker sees what arrived.
			st_d.resp_byte = acc.wdata; // RULE9
			st_d.resp_valid = 1'b1;
			st_d.ans_err = wrong;
			if (!late) begin
				st_d.answers = count_base + 3'h1;
			end
		end
		if (trig) begin
			st_d.trig_seen = 1'b1;
		end
		// Sets come after clears so an event in a clearing cycle is never lost.
		if (changing) begin
			st_d.changed = 1'b1; // RULE2
		end
		if (wrong || late) begin
			st_d.seq_fault = 1'b1; // RULE3
		end
		if (seq.in_window1 && (trig || fourth)) begin
			st_d.early = 1'b1; // RULE8
		end
		if (seq.seq_end && missing) begin
			st_d.timeout = 1'b1; // RULE4 RULE5
		end
		if (diag_state && acc.flags_wr && acc.wdata[WDSR_TIMEOUT_BIT]) begin
			st_d.timeout = 1'b1; // RULE7 RULE12
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= '{
				early: 1'b0, timeout: 1'b0, seq_fault: 1'b0, changed: 1'b0,
				invalid: 1'b0, ans_err: 1'b0, answers: 3'h0, trig_seen: 1'b0,
				win1_prev: WDSR_WIN1_RESET, win2_prev: WDSR_WIN2_RESET,
				resp_byte: WDSR_BYTE_RESET, rd_data: WDSR_BYTE_RESET, resp_valid: 1'b0
			};
		end else begin
			st_q <= st_d;
		end
	end

	assign flags_rdata = st_q.rd_data;
	assign response_byte = st_q.resp_byte;
	assign response_valid = st_q.resp_valid;
	assign wd_failure = st_q.timeout; // RULE7
	// The sequence verdict is judged at its end; an unserved sequence, a sequence fault or the premature flag makes a bad end.
	assign good_event = seq.seq_end && !missing && !st_q.seq_fault && !st_q.early;
	assign bad_event = seq.seq_end && !good_event;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence seq_ends_unserved;
		seq.seq_end && missing;
	endsequence

	invalid_window_a: assert property ((first_window_duration == WDSR_WIN1_ZERO) |=> st_q.invalid) // RULE1
		else $error("invalid window flag not set for zero first window");
	changed_set_a: assert property (changing |=> st_q.changed) // RULE2
		else $error("window change not flagged");
	changed_clear_a: assert property (seq.seq_start && !changing |=> !st_q.changed) // RULE2
		else $error("window change flag survived sequence start");
	fault_on_wrong_a: assert property (wrong |=> st_q.seq_fault) // RULE3
		else $error("wrong response byte not flagged");
	timeout_set_a: assert property (seq_ends_unserved |=> st_q.timeout && wd_failure) // RULE4 RULE5
		else $error("unserved sequence did not time out");
	timeout_read_clr_a: assert property (acc.flags_rd && !(seq.seq_end && missing) &&
		!(diag_state && acc.flags_wr) |=> !st_q.timeout) // RULE6
		else $error("time-out flag not cleared by read");
	timeout_good_clr_a: assert property (good_event && !acc.flags_wr |=> !st_q.timeout) // RULE6
		else $error("time-out flag not cleared by good event");
	diag_write_a: assert property (diag_state && acc.flags_wr && acc.wdata[WDSR_TIMEOUT_BIT]
		|=> wd_failure) // RULE7
		else $error("diagnostic write did not set time-out");
	nondiag_write_a: assert property (!diag_state && acc.flags_wr && !st_q.timeout &&
		!seq.seq_end |=> !st_q.timeout) // RULE12
		else $error("flag write accepted outside diagnostics");
	early_trigger_a: assert property (trig && seq.in_window1 |=> st_q.early) // RULE8
		else $error("early trigger not flagged");
	response_store_a: assert property (answer |=> response_valid &&
		response_byte == $past(acc.wdata)) // RULE9
		else $error("response byte not captured");
	count_report_a: assert property (qa_mode && acc.flags_rd && $stable(qa_mode) |=>
		flags_rdata[7:6] == $past(st_q.answers[1:0])) // RULE11
		else $error("answer count not reported");

	// Steps of the longer checks, kept apart so that each step reads on its own.
	sequence diag_sets_timeout;
		diag_state && acc.flags_wr && acc.wdata[WDSR_TIMEOUT_BIT];
	endsequence

	sequence timeout_left_alone;
		!acc.flags_rd && !seq.seq_end;
	endsequence

	sequence quiet_served_end;
		seq.seq_end && !missing && !(diag_state && acc.flags_wr);
	endsequence

	sequence window1_service;
		seq.in_window1 && (trig || fourth);
	endsequence

	invalid_second_a: assert property ((second_window_duration == WDSR_WIN2_ZERO) // RULE1
		|=> st_q.invalid)
		else $error("invalid window flag not set for zero second window");

	valid_window_a: assert property ((first_window_duration != WDSR_WIN1_ZERO) && // RULE1
		(second_window_duration != WDSR_WIN2_ZERO) |=> !st_q.invalid)
		else $error("invalid window flag set for valid windows");

	changed_hold_a: assert property (st_q.changed && !seq.seq_start // RULE2
		|=> st_q.changed)
		else $error("window change flag lost before sequence start");

	fault_on_late_a: assert property (late // RULE3
		|=> st_q.seq_fault)
		else $error("extra response byte not flagged");

	fault_clear_a: assert property (seq.seq_start && !wrong && !late // RULE3
		|=> !st_q.seq_fault)
		else $error("sequence fault survived sequence start");

	fault_qa_only_a: assert property (!qa_mode && !st_q.seq_fault // RULE3
		|=> !st_q.seq_fault)
		else $error("sequence fault set in trigger mode");

	answer_error_a: assert property (wrong // RULE3
		|=> st_q.ans_err)
		else $error("answer error not set for wrong byte");

	answer_right_a: assert property (answer && !wrong // RULE3
		|=> !st_q.ans_err)
		else $error("answer error not cleared by correct byte");

	timeout_trigger_a: assert property (!qa_mode && seq.seq_end && !st_q.trig_seen // RULE4
		|=> wd_failure)
		else $error("missing trigger did not time out");

	timeout_answers_a: assert property (qa_mode && seq.seq_end && // RULE5
		(st_q.answers < WDSR_ANSWERS_PER_SEQ) |=> st_q.timeout)
		else $error("short answer sequence did not time out");

	served_clear_a: assert property (quiet_served_end // RULE6
		|=> !st_q.timeout)
		else $error("time-out flag not cleared by served sequence end");

	bad_on_timeout_a: assert property (seq_ends_unserved // RULE6
		|-> bad_event && !good_event)
		else $error("unserved sequence end not reported as bad");

	event_verdict_a: assert property (seq.seq_end // RULE6
		|-> good_event != bad_event)
		else $error("sequence end without a single verdict");

	event_idle_a: assert property (!seq.seq_end // RULE6
		|-> !good_event && !bad_event)
		else $error("verdict outside sequence end");

	diag_held_a: assert property (diag_sets_timeout ##1 timeout_left_alone // RULE7
		|=> wd_failure)
		else $error("diagnostic time-out did not stay set");

	timeout_hold_a: assert property (st_q.timeout && !acc.flags_rd && !seq.seq_end // RULE7
		|=> st_q.timeout)
		else $error("time-out flag dropped without a clearing event");

	early_window_a: assert property (window1_service // RULE8
		|=> st_q.early)
		else $error("service in first window not flagged");

	early_fourth_a: assert property (fourth && seq.in_window1 // RULE8
		|=> st_q.early)
		else $error("fourth byte in first window not flagged");

	early_clear_a: assert property (seq.seq_start && !seq.in_window1 // RULE8
		|=> !st_q.early)
		else $error("premature flag survived sequence start");

	early_only_window1_a: assert property (!st_q.early && !seq.in_window1 // RULE8
		|=> !st_q.early)
		else $error("premature flag set outside first window");

	response_pulse_a: assert property (!answer // RULE9
		|=> !response_valid)
		else $error("response valid without a response byte");

	trigger_mode_byte_a: assert property (!qa_mode && acc.resp_wr // RULE9
		|=> !response_valid && $stable(response_byte))
		else $error("response byte taken in trigger mode");

	count_clear_a: assert property (seq.seq_start && !answer // RULE11
		|=> st_q.answers == 3'h0)
		else $error("answer count not cleared at sequence start");

	count_step_a: assert property (answer && !late // RULE11
		|=> st_q.answers == $past(count_base) + 3'h1)
		else $error("answer count did not step");

	count_trigger_mode_a: assert property (!qa_mode && acc.flags_rd // RULE11
		|=> flags_rdata[7:6] == 2'h0)
		else $error("answer count shown in trigger mode");

	snapshot_a: assert property (acc.flags_rd // RULE12
		|=> flags_rdata == $past(flags))
		else $error("status read did not return the flags");

	read_keeps_flags_a: assert property (acc.flags_rd && !seq.seq_start // RULE12
		|=> (st_q.changed || !$past(st_q.changed)) &&
		(st_q.seq_fault || !$past(st_q.seq_fault)) && (st_q.early || !$past(st_q.early)))
		else $error("status read cleared a flag other than time-out");
endmodule

`default_nettype wire

// file: shared/wdsr_pkg.sv
package wdsr_pkg;
	localparam int WDSR_EARLY_BIT = 0;
	localparam int WDSR_TIMEOUT_BIT = 1;
	localparam int WDSR_SEQ_FAULT_BIT = 2;
	localparam int WDSR_CHANGED_BIT = 3;
	localparam int WDSR_INVALID_BIT = 4;
	localparam int WDSR_ANS_ERR_BIT = 5;
	localparam int WDSR_COUNT_LSB = 6;
	localparam logic [6:0] WDSR_WIN1_RESET = 7'h7F;
	localparam logic [4:0] WDSR_WIN2_RESET = 5'h18;
	localparam logic [6:0] WDSR_WIN1_ZERO = 7'h00;
	localparam logic [4:0] WDSR_WIN2_ZERO = 5'h00;
	localparam logic [7:0] WDSR_BYTE_RESET = 8'h00;
	localparam logic [2:0] WDSR_ANSWERS_PER_SEQ = 3'h4;

	// Sequence events seen by the flag logic in one cycle.
	typedef struct packed {
		logic seq_start;
		logic seq_end;
		logic in_window1;
		logic trigger;
	} wdsr_seq_t;

	// Register access strobes of the serial command decoder.
	typedef struct packed {
		logic flags_rd;
		logic flags_wr;
		logic resp_wr;
		logic [7:0] wdata;
	} wdsr_acc_t;

	typedef struct packed {
		logic early;
		logic timeout;
		logic seq_fault;
		logic changed;
		logic invalid;
		logic ans_err;
		logic [2:0] answers;
		logic trig_seen;
		logic [6:0] win1_prev;
		logic [4:0] win2_prev;
		logic [7:0] resp_byte;
		logic [7:0] rd_data;
		logic resp_valid;
	} wdsr_state_t;
endpackage

// file: verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
	import wdsr_pkg::*;
;
	logic mclk = 0;
	logic rst = 1;
	logic qa = 0;
	logic diag = 0;
	logic pin = 0;
	logic [6:0] w1 = WDSR_WIN1_RESET;
	logic [4:0] w2 = WDSR_WIN2_RESET;
	wdsr_seq_t seq = '0;
	wdsr_acc_t acc;
	logic [2:0] req = 3'h0;
	logic [7:0] wd = 8'h00;
	logic [7:0] ans = 8'h00;
	logic [7:0] fl;
	logic [7:0] rb;
	logic rv;
	logic fail;
	logic ge;
	logic be;
	logic ev_good = 0;
	logic ev_bad = 0;
	logic valid_seen = 0;
	int errors = 0;
	int checks_done = 0;
	wdsr_host host (.mclk(mclk), .req(req), .data(wd), .acc(acc));
	wdsr_top dut (.mclk(mclk), .rst(rst), .qa_mode(qa), .diag_state(diag),
		.first_window_duration(w1), .second_window_duration(w2), .seq(seq),
		.error_trigger_pin(pin), .acc(acc), .expected_answer(ans), .flags_rdata(fl),
		.response_byte(rb), .response_valid(rv), .wd_failure(fail), .good_event(ge),
		.bad_event(be));
	initial begin
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Request codes: 4 reads the flags, 2 writes them, 1 writes a response byte.
	task automatic op(input logic [2:0] r, input logic [7:0] d);
		req <= r;
		wd <= d;
		@(posedge mclk);
		req <= 3'h0;
		@(posedge mclk);
		@(negedge mclk);
		valid_seen = rv;
		repeat (2) @(posedge mclk);
	endtask
	task automatic pulse(input wdsr_seq_t s);
		seq <= s;
		@(negedge mclk);
		ev_good = ge;
		ev_bad = be;
		@(posedge mclk);
		seq <= '0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic t_window();
		op(3'h1, 8'hA5);
		chk(rb, 8'h00);
		chk({7'h0, valid_seen}, 8'h00);
		op(3'h4, 8'h00);
		chk(fl, 8'h00);
		w1 <= WDSR_WIN1_ZERO;
		op(3'h4, 8'h00);
		chk(fl, 8'h18);
		w1 <= WDSR_WIN1_RESET;
		repeat (2) @(posedge mclk);
		pulse(4'h8);
		op(3'h4, 8'h00);
		chk(fl, 8'h00);
	endtask
	task automatic t_timeout();
		pulse(4'h8);
		pulse(4'h4);
		chk({7'h0, fail}, 8'h01);
		chk({6'h0, ev_good, ev_bad}, 8'h01);
		// The host takes the time-out as its cue to restart its own schedule.
		pulse(4'h8);
		op(3'h2, 8'h00);
		op(3'h4, 8'h00);
		chk(fl & 8'h02, 8'h02);
		op(3'h4, 8'h00);
		chk(fl, 8'h00);
	endtask
	task automatic t_early_diag();
		pulse(4'h8);
		pin <= 1;
		pulse(4'h3);
		pin <= 0;
		op(3'h4, 8'h00);
		chk(fl & 8'h01, 8'h01);
		diag <= 1;
		op(3'h2, 8'h02);
		chk({7'h0, fail}, 8'h01);
		diag <= 0;
		op(3'h4, 8'h00);
		chk({7'h0, fail}, 8'h00);
		diag <= 1;
		op(3'h2, 8'h02);
		diag <= 0;
		pulse(4'h8);
		pin <= 1;
		pulse(4'h1);
		pin <= 0;
		pulse(4'h4);
		chk({6'h0, ev_good, ev_bad}, 8'h02);
		chk({7'h0, fail}, 8'h00);
	endtask
	task automatic t_answers();
		qa <= 1;
		ans <= 8'hA5;
		pulse(4'h8);
		op(3'h1, 8'hA5);
		op(3'h1, 8'hA5);
		chk(rb, 8'hA5);
		op(3'h4, 8'h00);
		chk(fl, 8'h80);
		chk({7'h0, valid_seen}, 8'h00);
		pulse(4'h4);
		chk({7'h0, fail}, 8'h01);
		chk({6'h0, ev_good, ev_bad}, 8'h01);
		pulse(4'h8);
		op(3'h1, 8'h5A);
		op(3'h4, 8'h00);
		op(3'h4, 8'h00);
		chk(fl & 8'h24, 8'h24);
	endtask
	task automatic t_full();
		pulse(4'h8);
		repeat (4) op(3'h1, 8'hA5);
		chk({7'h0, valid_seen}, 8'h01);
		pulse(4'h4);
		chk({6'h0, ev_good, ev_bad}, 8'h02);
		chk({7'h0, fail}, 8'h00);
		pulse(4'h8);
		repeat (3) op(3'h1, 8'hA5);
		seq <= 4'h2;
		op(3'h1, 8'hA5);
		seq <= '0;
		op(3'h1, 8'hA5);
		op(3'h4, 8'h00);
		chk(fl, 8'h05);
	endtask
	task automatic t_reset();
		diag <= 1;
		op(3'h2, 8'h02);
		diag <= 0;
		chk({7'h0, fail}, 8'h01);
		rst <= 1;
		repeat (2) @(posedge mclk);
		chk({7'h0, fail}, 8'h00);
		rst <= 0;
		@(posedge mclk);
		op(3'h4, 8'h00);
		chk(fl, 8'h00);
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge mclk);
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		t_window();
		t_timeout();
		t_early_diag();
		t_answers();
		t_full();
		t_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// file: verification/wdsr_host.sv
`timescale 1ns/1ns
`default_nettype none
module wdsr_host
	import wdsr_pkg::*;
(
	input wire logic mclk,
	input wire logic [2:0] req,
	input wire logic [7:0] data,
	output var wdsr_acc_t acc
);
	// Each request becomes a one-cycle strobe with its byte carried whole beside it.
	always_ff @(posedge mclk) begin
		acc <= {req, data};
	end
endmodule
`default_nettype wire
